// ===== hdl/pclo_cfg.svh
`ifndef PCLO_CFG_SVH
`define PCLO_CFG_SVH

`define PCLO_NUM_PINS        12
`define PCLO_SRC_W           4
`define PCLO_EXT_RST_LIMIT   2'h1
`define PCLO_ST_RST          2'h0
`define PCLO_CNT_W           16

`endif

// ===== hdl/pclo_override.sv
`timescale 1ns/1ns
`include "pclo_cfg.svh"
// ----------------------------------------------------------------------------
// Notes on behaviour
// - limit input chosen from twelve pins
// - limit asserted with enable forces limit values
// - current reset clears timebase in mode
// - status shows flag, else limit level
// - polarity bit inverts limit input
// - all limit requests ORed into one
// - pin levels readable through port path
// - fault override beats current-limit override
// - selected trip and limit go to ADC
// - ownership priority generator up to pin enable
// - low override goes low immediately, gated twice
// - asserted override passes clocked dead-time stage
// - immediate update passes duty writes at once
// - pin enables give module the pins
// - manual override replaces generator bit
// - overrides in complementary mode keep dead time
// - sync bit applies manual override at zero
// - timebase stopped, control writes next cycle
// - reset tri-states pins, registers default
// - sleep keeps fault path live, wakes cpu
// - idle stop halts module like sleep
// - override bit selects active or inactive level
// - fault entry to low level asynchronous, high level waits one clock
// ----------------------------------------------------------------------------
module pclo_override
  import pclo_pkg::*;
(
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       clk_en,
  input  wire logic                       module_enable,
  input  wire logic                       timebase_run_enable,
  input  wire logic                       idle_mode,
  input  wire logic                       sleep_mode,
  input  wire logic                       idle_stop_select,
  input  wire logic                       immediate_duty_update,
  input  wire logic                       duty_write,
  input  wire logic                       cycle_boundary,
  input  wire logic                       iocon_write,
  input  wire logic                       limit_flag_clear,
  input  wire logic [`PCLO_CNT_W-1:0]     generator_timebase_count,
  input  wire logic [`PCLO_NUM_PINS-1:0]  trip_pins,
  input  wire logic [`PCLO_NUM_PINS-1:0]  other_limit_irq,
  input  wire pclo_pkg::pclo_limcfg_s     limit_cfg,
  input  wire pclo_pkg::pclo_iocfg_s      io_cfg,
  input  wire logic                       gen_high,
  input  wire logic                       gen_low,
  input  wire logic                       gpio_high,
  input  wire logic                       gpio_low,
  input  wire logic                       gpio_high_oe,
  input  wire logic                       gpio_low_oe,
  output logic                            high_side_output,
  output logic                            low_side_output,
  output logic                            high_side_oe,
  output logic                            low_side_oe,
  output logic                            limit_state_flag,
  output logic                            limit_irq_request,
  output logic                            timebase_reset,
  output logic                            duty_load,
  output logic                            adc_trip_trigger,
  output logic                            adc_limit_trigger,
  output logic                            wake_request,
  output logic [`PCLO_NUM_PINS-1:0]       port_read_value
);
  import pclo_pkg::*;

  // --------------------------------------------------------------------------
  // pin synchronisers (only for clocked users)
  // --------------------------------------------------------------------------
  logic [`PCLO_NUM_PINS-1:0] pin_s1_q;
  logic [`PCLO_NUM_PINS-1:0] pin_s2_q;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else if (clk_en) begin
      pin_s1_q <= trip_pins;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign port_read_value = pin_s2_q;

  // --------------------------------------------------------------------------
  // source selection (asynchronous path)
  // --------------------------------------------------------------------------
  logic limit_raw;
  logic trip_raw;
  logic limit_async;
  logic trip_async;
  logic limit_sync;
  logic halted;

  always_comb begin
    limit_raw = 1'b0;
    trip_raw  = 1'b0;
    if (limit_cfg.limit_source_select < 4'(`PCLO_NUM_PINS)) begin
      limit_raw = trip_pins[limit_cfg.limit_source_select];
    end
    if (limit_cfg.trip_source_select < 4'(`PCLO_NUM_PINS)) begin
      trip_raw = trip_pins[limit_cfg.trip_source_select];
    end
  end

  assign limit_async = limit_raw ^ limit_cfg.limit_polarity_invert;
  assign trip_async  = (trip_raw ^ limit_cfg.trip_polarity_invert) & limit_cfg.trip_enable;
  assign limit_sync  = (limit_cfg.limit_source_select < 4'(`PCLO_NUM_PINS))
                     ? (pin_s2_q[limit_cfg.limit_source_select] ^ limit_cfg.limit_polarity_invert)
                     : 1'b0;

  assign adc_trip_trigger  = trip_async;
  assign adc_limit_trigger = limit_async;

  assign halted       = sleep_mode | (idle_mode & idle_stop_select);
  assign wake_request = halted & trip_async;

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  pclo_state_s st_q;
  pclo_state_s st_d;
  logic        run;
  logic        at_zero;
  logic        limit_active;
  logic        h_pre;
  logic        l_pre;

  assign run     = clk_en & ~halted;
  assign at_zero = (generator_timebase_count == '0);

  always_comb begin
    st_d = st_q;
    // manual override capture
    if (iocon_write) begin
      if (!timebase_run_enable || !io_cfg.override_sync_enable) begin
        st_d.manual_h_en = io_cfg.high_manual_override_enable;
        st_d.manual_l_en = io_cfg.low_manual_override_enable;
        st_d.manual_val  = io_cfg.manual_override_value;
      end
    end
    if (io_cfg.override_sync_enable && timebase_run_enable && at_zero) begin
      st_d.manual_h_en = io_cfg.high_manual_override_enable;
      st_d.manual_l_en = io_cfg.low_manual_override_enable;
      st_d.manual_val  = io_cfg.manual_override_value;
    end
    // limit interrupt flag, set wins over clear
    if (limit_flag_clear || !limit_cfg.limit_irq_enable) begin
      st_d.limit_irq_flag = 1'b0;
    end
    if (limit_cfg.limit_irq_enable && limit_sync) begin
      st_d.limit_irq_flag = 1'b1;
    end
    st_d.limit_seen = limit_sync;
    // limit hold until next cycle boundary
    case (st_q.lim_state)
      PCLO_OWN_GEN: begin
        if (limit_sync && limit_cfg.limit_irq_enable) begin
          st_d.lim_state = PCLO_OWN_LIMIT;
        end
      end
      PCLO_OWN_LIMIT: begin
        if (!limit_sync) begin
          st_d.lim_state = timebase_run_enable ? PCLO_OWN_HOLD : PCLO_OWN_GEN;
        end
      end
      PCLO_OWN_HOLD: begin
        if (limit_sync && limit_cfg.limit_irq_enable) begin
          st_d.lim_state = PCLO_OWN_LIMIT;
        end else if (cycle_boundary || !timebase_run_enable) begin
          st_d.lim_state = PCLO_OWN_GEN;
        end
      end
      default: begin
        st_d.lim_state = PCLO_OWN_GEN;
      end
    endcase
    if (!limit_cfg.limit_irq_enable) begin
      st_d.lim_state = PCLO_OWN_GEN;
    end
    st_d.dt_h = h_pre;
    st_d.dt_l = l_pre;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{manual_h_en: 1'b0, manual_l_en: 1'b0, manual_val: 2'h0, limit_irq_flag: 1'b0,
                lim_state: PCLO_OWN_GEN, dt_h: 1'b0, dt_l: 1'b0, limit_seen: 1'b0};
    end else if (run) begin
      st_q <= st_d;
    end
  end

  // --------------------------------------------------------------------------
  // override priority and dead-time gating
  // --------------------------------------------------------------------------
  assign limit_active = limit_cfg.limit_irq_enable &
                        (limit_async | (st_q.lim_state != PCLO_OWN_GEN));

  always_comb begin
    h_pre = st_q.manual_h_en ? st_q.manual_val[1] : gen_high;
    l_pre = st_q.manual_l_en ? st_q.manual_val[0] : gen_low;
    if (limit_active) begin
      h_pre = io_cfg.limit_override_value[1];
      l_pre = io_cfg.limit_override_value[0];
    end
    if (trip_async) begin
      h_pre = io_cfg.trip_override_value[1];
      l_pre = io_cfg.trip_override_value[0];
    end
  end

  logic force_h_low;
  logic force_l_low;
  logic act_h;
  logic act_l;

  always_comb begin
    force_h_low = 1'b0;
    force_l_low = 1'b0;
    if (limit_active) begin
      force_h_low = ~io_cfg.limit_override_value[1];
      force_l_low = ~io_cfg.limit_override_value[0];
    end
    if (trip_async) begin
      force_h_low = ~io_cfg.trip_override_value[1];
      force_l_low = ~io_cfg.trip_override_value[0];
    end
  end

  // low limit or trip override levels bypass the clocked stage, high waits for it
  assign act_h = st_q.dt_h & ~force_h_low;
  assign act_l = st_q.dt_l & ~force_l_low;

  always_comb begin
    high_side_output = gpio_high;
    low_side_output  = gpio_low;
    high_side_oe     = gpio_high_oe;
    low_side_oe      = gpio_low_oe;
    if (!reset_n) begin
      high_side_oe = 1'b0;
      low_side_oe  = 1'b0;
    end else if (module_enable) begin
      if (io_cfg.high_pin_ownership) begin
        high_side_output = act_h ^ io_cfg.high_polarity_low;
        high_side_oe     = 1'b1;
      end
      if (io_cfg.low_pin_ownership) begin
        low_side_output = act_l ^ io_cfg.low_polarity_low;
        low_side_oe     = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // status, interrupt, current reset, duty update
  // --------------------------------------------------------------------------
  assign limit_state_flag  = limit_cfg.limit_irq_enable ? st_q.limit_irq_flag : limit_sync;
  assign limit_irq_request = st_q.limit_irq_flag | (|other_limit_irq);
  assign timebase_reset    = ~limit_cfg.limit_mode_bit & limit_async
                           & (limit_cfg.external_period_reset_select == `PCLO_EXT_RST_LIMIT)
                           & limit_cfg.independent_timebase_select;
  assign duty_load         = duty_write & (immediate_duty_update | cycle_boundary);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  trip_beats_limit_a: assert property (trip_async && limit_active && module_enable && io_cfg.high_pin_ownership
    && !io_cfg.trip_override_value[1] |-> high_side_output == io_cfg.high_polarity_low)
    else $error("trip override not winning");
  status_select_a: assert property (!limit_cfg.limit_irq_enable |-> limit_state_flag == limit_sync)
    else $error("status not showing input");
  irq_or_a: assert property (|other_limit_irq |-> limit_irq_request)
    else $error("irq not combined");
  reset_mode_a: assert property (limit_async && !limit_cfg.limit_mode_bit && limit_cfg.independent_timebase_select
    && limit_cfg.external_period_reset_select == 2'h1 |-> timebase_reset)
    else $error("timebase reset missing");
  flag_sets_a: assert property (run && limit_cfg.limit_irq_enable && limit_sync ##1 limit_cfg.limit_irq_enable
    |-> limit_state_flag)
    else $error("limit flag not set");
  gpio_owns_a: assert property (!module_enable |-> high_side_oe == gpio_high_oe && low_side_oe == gpio_low_oe)
    else $error("gpio lost pins");
  duty_now_a: assert property (duty_write && immediate_duty_update |-> duty_load)
    else $error("immediate update lost");
  wake_trip_a: assert property (sleep_mode && trip_async |-> wake_request)
    else $error("no wake on trip");

endmodule // pclo_override

// ===== hdl/pclo_pkg.sv
package pclo_pkg;

  typedef enum logic [1:0] {
    PCLO_OWN_GEN   = 2'b00,
    PCLO_OWN_LIMIT = 2'b01,
    PCLO_OWN_HOLD  = 2'b10
  } pclo_lim_e;

  typedef struct packed {
    logic [3:0] limit_source_select;
    logic [3:0] trip_source_select;
    logic       limit_polarity_invert;
    logic       trip_polarity_invert;
    logic       limit_mode_bit;
    logic [1:0] external_period_reset_select;
    logic       independent_timebase_select;
    logic       limit_irq_enable;
    logic       trip_enable;
  } pclo_limcfg_s;

  typedef struct packed {
    logic       high_pin_ownership;
    logic       low_pin_ownership;
    logic       high_manual_override_enable;
    logic       low_manual_override_enable;
    logic [1:0] manual_override_value;
    logic [1:0] limit_override_value;
    logic [1:0] trip_override_value;
    logic       override_sync_enable;
    logic       high_polarity_low;
    logic       low_polarity_low;
  } pclo_iocfg_s;

  typedef struct packed {
    logic       manual_h_en;
    logic       manual_l_en;
    logic [1:0] manual_val;
    logic       limit_irq_flag;
    pclo_lim_e  lim_state;
    logic       dt_h;
    logic       dt_l;
    logic       limit_seen;
  } pclo_state_s;

endpackage

// ===== test/pclo_limit_source.sv
`timescale 1ns/1ns
// ----------------------------------------
// far-side comparators and shared port pins
// ----------------------------------------
module pclo_limit_source (
  input  wire logic [11:0] comp_level,
  input  wire logic [11:0] port_dir_out,
  input  wire logic [11:0] port_data,
  output logic      [11:0] trip_pins
);
  // pin set as port output follows its data bit
  always_comb trip_pins = (port_dir_out & port_data) | (~port_dir_out & comp_level);
endmodule // pclo_limit_source

// ===== test/tb.sv
`timescale 1ns/1ns
// ----------------------------------------
// override stage bench
// ----------------------------------------
module tb;
  import pclo_pkg::*;
  logic         mclk = 0, reset_n = 0, mod_en = 0, run = 0, slp = 0, idu = 0;
  logic         dwr = 0, cbnd = 0, iow = 0, gh = 0, gl = 0, gp = 0, gpoe = 1;
  logic [11:0]  comp = 0, pdir = 0, pdat = 0, oirq = 0, pins, prd;
  pclo_limcfg_s lc = '0;
  pclo_iocfg_s  io = '0;
  logic         ho, lo, hoe, loe, st, irq, tbr, dld, atr, alm, wk;
  int           n_mismatch = 0;
  int           checked = 0;

  always #4 mclk = ~mclk;

  pclo_limit_source far (.comp_level(comp), .port_dir_out(pdir), .port_data(pdat), .trip_pins(pins));

  pclo_override uut (
    .mclk(mclk), .reset_n(reset_n), .clk_en(1'b1), .module_enable(mod_en),
    .timebase_run_enable(run), .idle_mode(1'b0), .sleep_mode(slp), .idle_stop_select(1'b0),
    .immediate_duty_update(idu), .duty_write(dwr), .cycle_boundary(cbnd), .iocon_write(iow),
    .limit_flag_clear(1'b0), .generator_timebase_count(16'h0000), .trip_pins(pins),
    .other_limit_irq(oirq), .limit_cfg(lc), .io_cfg(io), .gen_high(gh), .gen_low(gl),
    .gpio_high(gp), .gpio_low(~gp), .gpio_high_oe(gpoe), .gpio_low_oe(gpoe),
    .high_side_output(ho), .low_side_output(lo), .high_side_oe(hoe), .low_side_oe(loe),
    .limit_state_flag(st), .limit_irq_request(irq), .timebase_reset(tbr), .duty_load(dld),
    .adc_trip_trigger(atr), .adc_limit_trigger(alm), .wake_request(wk), .port_read_value(prd)
  );

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial begin
    #20000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    #1;
    chk({hoe, loe}, 2'b00);
    step(6);
    reset_n = 1;
    gp = 1;
    step(2);
    chk({ho, lo}, 2'b10);
    mod_en = 1;
    io.high_pin_ownership = 1;
    io.low_pin_ownership = 1;
    gh = 1;
    step(3);
    chk({hoe, loe, ho, lo}, 4'b1110);
    io.high_manual_override_enable = 1;
    io.low_manual_override_enable = 1;
    io.manual_override_value = 2'b01;
    iow = 1;
    step(1);
    iow = 0;
    step(2);
    chk({ho, lo}, 2'b01);
    $display("test ownership done");
    lc.limit_source_select = 4'h3;
    lc.limit_irq_enable = 1;
    comp[3] = 1;
    #1;
    chk({ho, lo}, 2'b00);
    chk(alm, 1'b1);
    step(4);
    chk(st, 1'b1);
    chk(irq, 1'b1);
    io.limit_override_value = 2'b10;
    step(2);
    chk({ho, lo}, 2'b10);
    lc.trip_enable = 1;
    lc.trip_source_select = 4'h5;
    comp[5] = 1;
    #1;
    chk({ho, lo}, 2'b00);
    chk(atr, 1'b1);
    comp[5] = 0;
    step(3);
    chk({ho, lo}, 2'b10);
    run = 1;
    comp[3] = 0;
    step(3);
    chk({ho, lo}, 2'b10);
    cbnd = 1;
    step(1);
    cbnd = 0;
    step(2);
    chk({ho, lo}, 2'b01);
    $display("test limit and trip done");
    lc.limit_irq_enable = 0;
    lc.limit_polarity_invert = 1;
    pdir[3] = 1;
    step(2);
    chk(st, 1'b1);
    chk({ho, lo}, 2'b01);
    lc.external_period_reset_select = 2'b01;
    lc.independent_timebase_select = 1;
    #1;
    chk(tbr, 1'b1);
    lc.external_period_reset_select = 2'b10;
    #1;
    chk(tbr, 1'b0);
    lc.limit_source_select = 4'hc;
    #1;
    chk(st, 1'b0);
    pdir = 0;
    comp = 12'ha5c;
    step(4);
    chk(prd, 12'ha5c);
    oirq = 12'h010;
    #1;
    chk(irq, 1'b1);
    idu = 1;
    dwr = 1;
    #1;
    chk(dld, 1'b1);
    idu = 0;
    #1;
    chk(dld, 1'b0);
    dwr = 0;
    $display("test status done");
    slp = 1;
    comp[5] = 1;
    #1;
    chk(wk, 1'b1);
    step(1);
    reset_n = 0;
    #1;
    chk({hoe, loe}, 2'b00);
    $display("test sleep and reset done");
    finish_test();
  end
endmodule // tb
